/* bench/pmoc_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus-side host: one-cycle strobes launched at the falling edge.
module pmoc_host (
    input wire logic mclk_in, // Device clock.
    output logic opt_wr_out, // Options write strobe.
    output logic [15:0] opt_wdata_out, // Options write data.
    output logic opt_rd_out, // Options read strobe.
    output logic [2:0] cmd_out // Store-all, failed guarded write, alert answered.
);
    initial begin
        opt_wr_out = 1'b0;
        opt_wdata_out = 16'h0000;
        opt_rd_out = 1'b0;
        cmd_out = 3'h0;
    end
    // Data is inverted once the strobe drops, so a stale word never passes for a write.
    task automatic wr(input logic [15:0] d);
        @(negedge mclk_in);
        opt_wr_out = 1'b1;
        opt_wdata_out = d;
        @(negedge mclk_in);
        opt_wr_out = 1'b0;
        opt_wdata_out = ~d;
    endtask
    task automatic rd();
        @(negedge mclk_in);
        opt_rd_out = 1'b1;
        @(negedge mclk_in);
        opt_rd_out = 1'b0;
    endtask
    task automatic cmd(input int i);
        @(negedge mclk_in);
        cmd_out[i] = 1'b1;
        @(negedge mclk_in);
        cmd_out[i] = 1'b0;
    endtask
endmodule

/* bench/power_module_options_control_tb_top.sv */
`timescale 1ns/1ps
module power_module_options_control_tb_top;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic opt_wr, opt_rd, nv_save, vrest, acc, rej, invalid_data_flag, alert;
    logic nv_load, smp_valid;
    logic obs = 1'b0, rd_d = 1'b0, obs_d = 1'b0;
    logic [15:0] opt_wdata, rdata, nv_data, mlo, mhi;
    logic [15:0] nv_in;
    logic [15:0] opt = pmoc_pkg::OPT_RESET;
    logic [2:0] cmd;
    logic [3:0] sd;
    logic [1:0] scale, chan, dv;
    logic [7:0] faults, fmask;
    logic [11:0] smp, rv, ri, rt;
    logic [11:0] last_rd [3];
    logic [31:0] sum;
    logic [19:0] note;
    logic [19:0] lq[$];
    logic [13:0] eq[$];
    pmoc_pkg::pmoc_div_t div;
    int n_errors = 0, n_checks = 0, seed = 32'h5289e629;
    int nn[4] = '{16, 8, 32, 1};
    int sh[4] = '{4, 3, 5, 0};
    logic [1:0] cc[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    wire [13:0] ev = {acc, rej, invalid_data_flag, alert, vrest, nv_save, fmask};

    always #5 mclk_in = ~mclk_in;

    pmoc_host u_host (.mclk_in(mclk_in), .opt_wr_out(opt_wr), .opt_wdata_out(opt_wdata),
        .opt_rd_out(opt_rd), .cmd_out(cmd));
    pmoc_options #(.SMP_W(12), .NFAULT(8)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .opt_wr_in(opt_wr), .opt_wdata_in(opt_wdata), .opt_rd_in(opt_rd), .opt_rdata_out(rdata),
        .store_all_in(cmd[0]), .nv_save_out(nv_save), .nv_data_out(nv_data), .nv_load_in(nv_load),
        .nv_data_in(nv_in), .bad_write_in(cmd[1]), .write_accept_out(acc), .write_reject_out(rej),
        .invalid_data_flag_set_out(invalid_data_flag), .alert_req_out(alert), .ara_done_in(cmd[2]),
        .fault_active_in(faults), .fault_mask_set_out(fmask), .vout_scale_loop_in(scale),
        .vout_meas_divider_out(div), .fault_shutdown_in(sd[0]), .fault_restart_in(sd[1]),
        .cntl_shutdown_in(sd[2]), .input_undervoltage_shutdown_in(sd[3]), .vout_restore_out(vrest),
        .margin_low_restore_out(mlo), .margin_high_restore_out(mhi), .smp_valid_in(smp_valid),
        .smp_chan_in(chan), .smp_in(smp), .read_vout_out(rv), .read_iout_out(ri), .read_temp_out(rt));

    // ==========================================================
    // Comparison and closing report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (lq.size() + eq.size() != 0) begin
            n_errors++;
            $display("wrong value at %0t: expected results never appeared", $time);
        end
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [15:0] cur(input logic [3:0] k);
        case (k)
            4'h0: return rdata;
            4'h1: return nv_data;
            4'h2: return {4'h0, rv};
            4'h3: return {4'h0, ri};
            4'h4: return {4'h0, rt};
            4'h5: return {14'h0, div};
            4'h6: return mlo;
            default: return mhi;
        endcase
    endfunction

    // ==========================================================
    // Watcher: every result that shows takes the oldest note.
    always @(posedge mclk_in) begin
        rd_d <= opt_rd;
        obs_d <= obs;
    end
    always @(negedge mclk_in) begin
        if (rd_d || obs_d || nv_save !== 1'b0) begin
            if (lq.size() == 0) begin
                n_errors++;
                $display("wrong value at %0t: result with no note", $time);
            end else begin
                note = lq.pop_front();
                check(cur(note[19:16]), note[15:0]);
            end
        end
        if (ev !== 14'h0) begin
            if (eq.size() == 0) check({2'h0, ev}, 16'h0000);
            else check({2'h0, ev}, {2'h0, eq.pop_front()});
        end
    end

    // ==========================================================
    // Drivers
    task automatic wr(input logic [15:0] d);
        opt = d & pmoc_pkg::OPT_WR_MASK;
        u_host.wr(d);
    endtask
    task automatic rdchk();
        lq.push_back({4'h0, opt});
        u_host.rd();
    endtask
    task automatic look(input logic [3:0] k, input logic [15:0] v);
        lq.push_back({k, v});
        @(negedge mclk_in);
        obs = 1'b1;
        @(negedge mclk_in);
        obs = 1'b0;
    endtask
    task automatic send(input logic [1:0] ch, input int n);
        sum = 32'h0;
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_in);
            smp_valid = 1'b1;
            chan = ch;
            smp = 12'($random(seed));
            sum = sum + {20'h0, smp};
        end
        @(negedge mclk_in);
        smp_valid = 1'b0;
        smp = ~smp;
    endtask
    task automatic pulse_sd(input int i);
        @(negedge mclk_in);
        sd[i] = 1'b1;
        @(negedge mclk_in);
        sd[i] = 1'b0;
    endtask

    initial begin
        #200000;
        n_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        stop_test();
    end

    initial begin
        // Idle levels are driven here so that every stimulus input is a live variable.
        nv_load = 1'b0;
        smp_valid = 1'b0;
        nv_in = 16'h0000;
        sd = 4'h0;
        scale = 2'h0;
        chan = 2'h0;
        faults = 8'h00;
        smp = 12'h000;
        repeat (5) @(negedge mclk_in);
        rst_in = 1'b0;
        rdchk();
        look(4'h5, 16'h0000);
        look(4'h6, pmoc_pkg::MLO_RESTORE_0);
        look(4'h7, pmoc_pkg::MHI_RESTORE_0);
        for (int c = 0; c < 4; c++) begin
            wr((opt & 16'hff9f) | {9'h0, cc[c], 5'h0});
            for (int ch = 0; ch < 3; ch++) begin
                send(2'(ch), nn[c]);
                last_rd[ch] = 12'(sum >> sh[c]);
                look(4'(2 + ch), {4'h0, last_rd[ch]});
            end
        end
        // Fast mode on and off each restart the voltage average one sample short.
        wr((opt & 16'hff97) | 16'h0048);
        send(2'h0, 7);
        look(4'h2, 16'(sum >> 3));
        send(2'h1, 8);
        look(4'h3, {4'h0, last_rd[1]});
        send(2'h2, 8);
        look(4'h4, {4'h0, last_rd[2]});
        wr(opt & 16'hfff7);
        send(2'h0, 7);
        look(4'h2, 16'(sum >> 3));
        repeat (6) begin
            wr(16'($random(seed)));
            rdchk();
        end
        for (int i = 0; i < 4; i++) begin
            wr((opt & 16'h9fff) | {1'b0, 2'(i), 13'h0});
            look(4'h6, i[0] ? pmoc_pkg::MLO_RESTORE_1 : pmoc_pkg::MLO_RESTORE_0);
            look(4'h7, i[1] ? pmoc_pkg::MHI_RESTORE_1 : pmoc_pkg::MHI_RESTORE_0);
        end
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 4; s++) begin
                wr((opt & 16'hfcff) | {6'h0, 2'(r), 8'h0});
                scale = 2'(s);
                dv = (r == 0) ? ((s == 0) ? 2'h0 : (s == 1) ? 2'h1 : 2'h2) : 2'(3 - r);
                look(4'h5, {14'h0, dv});
            end
        end
        wr(opt & 16'hffef);
        eq.push_back(14'h1c00);
        u_host.cmd(1);
        wr(opt | 16'h0010);
        eq.push_back(14'h2000);
        u_host.cmd(1);
        wr(opt & 16'hffef);
        rdchk();
        faults = 8'($random(seed)) | 8'h01;
        wr(opt | 16'h0080);
        eq.push_back({6'h0, faults});
        u_host.cmd(2);
        wr(opt & 16'hff7f);
        u_host.cmd(2);
        wr(opt | 16'h0800);
        for (int i = 0; i < 4; i++) begin
            eq.push_back(14'h0200);
            pulse_sd(i);
        end
        wr(opt & 16'hf7ff);
        for (int i = 0; i < 4; i++) pulse_sd(i);
        wr(16'h7fff);
        lq.push_back({4'h1, 16'h7fff & pmoc_pkg::OPT_NV_MASK});
        eq.push_back(14'h0100);
        u_host.cmd(0);
        @(negedge mclk_in);
        nv_load = 1'b1;
        nv_in = 16'($random(seed));
        opt = (nv_in & pmoc_pkg::OPT_NV_MASK) | (opt & 16'h0018);
        @(negedge mclk_in);
        nv_load = 1'b0;
        nv_in = ~nv_in;
        rdchk();
        repeat (3) @(negedge mclk_in);
        stop_test();
    end
endmodule

/* src/pmoc_averager.sv */
`timescale 1ns/1ps
module pmoc_averager #(
    parameter int W = 12
) (
    input wire logic mclk_in, // Device clock.
    input wire logic rst_in, // Synchronous reset, active high.
    pmoc_avg_if.avg port // Samples in, averaged results out.
);
    localparam int AW = W + 5;

    logic [AW-1:0] acc_reg, acc_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [W-1:0] res_reg, res_next;
    logic resv_reg, resv_next;

    function automatic logic [2:0] avg_shift(input logic [1:0] code);
        case (code)
            pmoc_pkg::AVG_8: avg_shift = pmoc_pkg::SH_8;
            pmoc_pkg::AVG_32: avg_shift = pmoc_pkg::SH_32;
            default: avg_shift = pmoc_pkg::SH_16;
        endcase
    endfunction

    // ==========================================================
    // Accumulating average
    always_comb begin
        logic [AW-1:0] sum;
        logic [2:0] sh;
        sum = acc_reg + {5'h0, port.smp};
        sh = avg_shift(port.avg_code);
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        res_next = res_reg;
        resv_next = 1'b0;
        if (port.restart) begin
            // The dropped sample makes the first result short by one.
            acc_next = '0;
            cnt_next = 6'h1;
        end else if (port.smp_valid) begin
            if (port.avg_code == pmoc_pkg::AVG_BYPASS) begin
                res_next = port.smp;
                resv_next = 1'b1;
            end else if (cnt_reg + 6'h1 >= (6'h1 << sh)) begin
                res_next = W'(sum >> sh);
                resv_next = 1'b1;
                acc_next = '0;
                cnt_next = '0;
            end else begin
                acc_next = sum;
                cnt_next = cnt_reg + 6'h1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            res_reg <= '0;
            resv_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            res_reg <= res_next;
            resv_reg <= resv_next;
        end
    end

    assign port.res = res_reg;
    assign port.res_valid = resv_reg;

    a_bypass_every: assert property (@(posedge mclk_in) disable iff (rst_in)
        port.smp_valid && !port.restart && port.avg_code == pmoc_pkg::AVG_BYPASS
        |=> resv_reg && res_reg == $past(port.smp))
        else $error("Bypass sample did not update the result.");
endmodule

/* src/pmoc_avg_if.sv */
`timescale 1ns/1ps
interface pmoc_avg_if #(parameter int W = 12);
    logic [1:0] avg_code;
    logic restart;
    logic smp_valid;
    logic [W-1:0] smp;
    logic res_valid;
    logic [W-1:0] res;
    modport ctl (output avg_code, output restart, output smp_valid, output smp, input res_valid, input res);
    modport avg (input avg_code, input restart, input smp_valid, input smp, output res_valid, output res);
endinterface

/* src/pmoc_options.sv */
`timescale 1ns/1ps
module pmoc_options #(
    parameter int SMP_W = 12,
    parameter int NFAULT = 8
) (
    input wire logic mclk_in, // Device clock, 100 MHz.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic opt_wr_in, // Options write strobe.
    input wire logic [15:0] opt_wdata_in, // Options write data.
    input wire logic opt_rd_in, // Options read strobe.
    output logic [15:0] opt_rdata_out, // Options read data.
    input wire logic store_all_in, // Store-all-defaults command pulse.
    output logic nv_save_out, // Pulse: write nv_data_out to memory.
    output logic [15:0] nv_data_out, // Options image for memory.
    input wire logic nv_load_in, // Pulse: restore from memory.
    input wire logic [15:0] nv_data_in, // Image restored from memory.
    input wire logic bad_write_in, // Write to a guarded command failed limits.
    output logic write_accept_out, // Pulse: store the failed write anyway.
    output logic write_reject_out, // Pulse: discard the failed write.
    output logic invalid_data_flag_set_out, // Pulse: set invalid-data flag.
    output logic alert_req_out, // Pulse: raise the SMBus alert.
    input wire logic ara_done_in, // Pulse: alert response answered.
    input wire logic [NFAULT-1:0] fault_active_in, // Fault sources now set.
    output logic [NFAULT-1:0] fault_mask_set_out, // Pulse: mask these sources.
    input wire logic [1:0] vout_scale_loop_in, // Loop scale: 0=1, 1=0.5, 2=0.25.
    output pmoc_pkg::pmoc_div_t vout_meas_divider_out, // Measurement divider.
    input wire logic fault_shutdown_in, // Fault with shutdown response.
    input wire logic fault_restart_in, // Fault with restart response.
    input wire logic cntl_shutdown_in, // Controlled shutdown by control pin.
    input wire logic input_undervoltage_shutdown_in, // Low input voltage.
    output logic vout_restore_out, // Pulse: setpoint back to default.
    output logic [15:0] margin_low_restore_out, // Step-margin-low reset value.
    output logic [15:0] margin_high_restore_out, // Step-margin-high reset value.
    input wire logic smp_valid_in, // Measurement sample strobe.
    input wire logic [1:0] smp_chan_in, // Sample channel: 0 vout, 1 iout, 2 temp.
    input wire logic [SMP_W-1:0] smp_in, // Sample value.
    output logic [SMP_W-1:0] read_vout_out, // Output voltage reading.
    output logic [SMP_W-1:0] read_iout_out, // Output current reading.
    output logic [SMP_W-1:0] read_temp_out // Temperature reading.
);
    if (SMP_W < 2 || SMP_W > 26 || NFAULT < 1) begin : g_bad_param
        $error("pmoc_options: unsupported parameter values.");
    end

    // ==========================================================
    // Options register and its side effects
    logic [15:0] opt_reg, opt_next;
    logic [15:0] rdata_reg, rdata_next;
    logic save_reg, save_next;
    logic [15:0] nvd_reg, nvd_next;
    logic acc_reg, acc_next;
    logic rej_reg, rej_next;
    logic alert_reg, alert_next;
    logic [NFAULT-1:0] mask_reg, mask_next;
    pmoc_pkg::pmoc_div_t div_reg, div_next;
    logic vrst_reg, vrst_next;
    logic [15:0] mlo_reg, mlo_next;
    logic [15:0] mhi_reg, mhi_next;
    logic vsm_prev_reg;
    logic wlo, vout_only_fast_measure;
    logic [1:0] range;

    assign wlo = opt_reg[pmoc_pkg::B_WLO];
    assign vout_only_fast_measure = opt_reg[pmoc_pkg::B_VSM];
    assign range = opt_reg[pmoc_pkg::B_RANGE_HI:pmoc_pkg::B_RANGE_LO];

    always_comb begin
        opt_next = opt_reg;
        if (nv_load_in) begin
            // Restore keeps fields that have no backup as they are.
            opt_next = (nv_data_in & pmoc_pkg::OPT_NV_MASK) | (opt_reg & ~pmoc_pkg::OPT_NV_MASK);
        end
        if (opt_wr_in) begin
            opt_next = opt_wdata_in & pmoc_pkg::OPT_WR_MASK;
        end
        rdata_next = opt_rd_in ? opt_reg : rdata_reg;
        save_next = store_all_in;
        nvd_next = store_all_in ? (opt_reg & pmoc_pkg::OPT_NV_MASK) : nvd_reg;
        // A guarded write that fails limits is stored silently under override.
        acc_next = bad_write_in && wlo;
        rej_next = bad_write_in && !wlo;
        // Only a failed write raises an alert, so leaving override later is silent.
        alert_next = bad_write_in && !wlo;
        mask_next = (ara_done_in && opt_reg[pmoc_pkg::B_AUTO_ARA]) ? fault_active_in : '0;
        case (range)
            pmoc_pkg::RANGE_AUTO: begin
                case (vout_scale_loop_in)
                    pmoc_pkg::SCALE_ONE: div_next = pmoc_pkg::PMOC_DIV_HALF;
                    pmoc_pkg::SCALE_HALF: div_next = pmoc_pkg::PMOC_DIV_QUARTER;
                    default: div_next = pmoc_pkg::PMOC_DIV_EIGHTH;
                endcase
            end
            pmoc_pkg::RANGE_EIGHTH: div_next = pmoc_pkg::PMOC_DIV_EIGHTH;
            pmoc_pkg::RANGE_QUARTER: div_next = pmoc_pkg::PMOC_DIV_QUARTER;
            default: div_next = pmoc_pkg::PMOC_DIV_HALF;
        endcase
        vrst_next = opt_reg[pmoc_pkg::B_RST_VOUT] && (fault_shutdown_in || fault_restart_in
            || cntl_shutdown_in || input_undervoltage_shutdown_in);
        mlo_next = opt_reg[pmoc_pkg::B_MLO_SEL] ? pmoc_pkg::MLO_RESTORE_1 : pmoc_pkg::MLO_RESTORE_0;
        mhi_next = opt_reg[pmoc_pkg::B_MHI_SEL] ? pmoc_pkg::MHI_RESTORE_1 : pmoc_pkg::MHI_RESTORE_0;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            opt_reg <= pmoc_pkg::OPT_RESET;
            rdata_reg <= '0;
            save_reg <= 1'b0;
            nvd_reg <= '0;
            acc_reg <= 1'b0;
            rej_reg <= 1'b0;
            alert_reg <= 1'b0;
            mask_reg <= '0;
            div_reg <= pmoc_pkg::PMOC_DIV_HALF;
            vrst_reg <= 1'b0;
            mlo_reg <= pmoc_pkg::MLO_RESTORE_0;
            mhi_reg <= pmoc_pkg::MHI_RESTORE_0;
            vsm_prev_reg <= 1'b0;
        end else begin
            opt_reg <= opt_next;
            rdata_reg <= rdata_next;
            save_reg <= save_next;
            nvd_reg <= nvd_next;
            acc_reg <= acc_next;
            rej_reg <= rej_next;
            alert_reg <= alert_next;
            mask_reg <= mask_next;
            div_reg <= div_next;
            vrst_reg <= vrst_next;
            mlo_reg <= mlo_next;
            mhi_reg <= mhi_next;
            vsm_prev_reg <= vout_only_fast_measure;
        end
    end

    assign opt_rdata_out = rdata_reg;
    assign nv_save_out = save_reg;
    assign nv_data_out = nvd_reg;
    assign write_accept_out = acc_reg;
    assign write_reject_out = rej_reg;
    assign invalid_data_flag_set_out = alert_reg;
    assign alert_req_out = alert_reg;
    assign fault_mask_set_out = mask_reg;
    assign vout_meas_divider_out = div_reg;
    assign vout_restore_out = vrst_reg;
    assign margin_low_restore_out = mlo_reg;
    assign margin_high_restore_out = mhi_reg;

    // ==========================================================
    // Measurement averaging
    pmoc_avg_if #(.W(SMP_W)) ch_if [pmoc_pkg::NCH] ();
    logic [pmoc_pkg::NCH-1:0] res_valid;
    logic [SMP_W-1:0] res [pmoc_pkg::NCH];

    genvar gi;
    generate
        for (gi = 0; gi < pmoc_pkg::NCH; gi++) begin : g_ch
            assign ch_if[gi].avg_code = opt_reg[pmoc_pkg::B_AVG_HI:pmoc_pkg::B_AVG_LO];
            // Only the voltage averager restarts when fast mode changes.
            assign ch_if[gi].restart = (gi == 0) && (vout_only_fast_measure != vsm_prev_reg);
            // Fast mode starves the current and temperature averagers.
            assign ch_if[gi].smp_valid = smp_valid_in && (smp_chan_in == 2'(gi))
                && (gi == 0 || !vout_only_fast_measure);
            assign ch_if[gi].smp = smp_in;
            assign res_valid[gi] = ch_if[gi].res_valid;
            assign res[gi] = ch_if[gi].res;
            pmoc_averager #(.W(SMP_W)) u_avg (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .port(ch_if[gi])
            );
        end
    endgenerate

    logic [SMP_W-1:0] rv_reg, rv_next, ri_reg, ri_next, rt_reg, rt_next;

    always_comb begin
        rv_next = res_valid[pmoc_pkg::CH_VOUT] ? res[pmoc_pkg::CH_VOUT] : rv_reg;
        ri_next = res_valid[pmoc_pkg::CH_IOUT] ? res[pmoc_pkg::CH_IOUT] : ri_reg;
        rt_next = res_valid[pmoc_pkg::CH_TEMP] ? res[pmoc_pkg::CH_TEMP] : rt_reg;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rv_reg <= '0;
            ri_reg <= '0;
            rt_reg <= '0;
        end else begin
            rv_reg <= rv_next;
            ri_reg <= ri_next;
            rt_reg <= rt_next;
        end
    end

    assign read_vout_out = rv_reg;
    assign read_iout_out = ri_reg;
    assign read_temp_out = rt_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_override_accepts: assert property (bad_write_in && wlo |=> write_accept_out && !alert_req_out)
        else $error("Override did not accept a failed write.");
    a_override_silent: assert property (wlo |=> !invalid_data_flag_set_out)
        else $error("Invalid-data flag set while override active.");
    a_leave_quiet: assert property ($fell(wlo) && !bad_write_in |=> !alert_req_out)
        else $error("Alert raised on leaving override.");
    a_normal_rejects: assert property (bad_write_in && !wlo |=> write_reject_out && alert_req_out)
        else $error("Failed write not rejected.");
    a_nv_image: assert property (store_all_in |=> nv_save_out && nv_data_out[pmoc_pkg::B_WLO] == 1'b0
        && nv_data_out[pmoc_pkg::B_VSM] == 1'b0)
        else $error("Store image wrong.");
    a_load_keeps: assert property (nv_load_in && !opt_wr_in |=> wlo == $past(wlo))
        else $error("Restore changed the override field.");
    a_auto_mask: assert property (ara_done_in |=> fault_mask_set_out ==
        ($past(opt_reg[pmoc_pkg::B_AUTO_ARA]) ? $past(fault_active_in) : '0))
        else $error("Auto mask wrong after alert response.");
    a_forced_div: assert property (range == pmoc_pkg::RANGE_QUARTER |=> div_reg == pmoc_pkg::PMOC_DIV_QUARTER)
        else $error("Range code did not force the divider.");
    a_restore_vout: assert property (cntl_shutdown_in && opt_reg[pmoc_pkg::B_RST_VOUT] |=> vout_restore_out)
        else $error("Setpoint restore missing on shutdown.");
    a_margin_vals: assert property (##1 margin_low_restore_out == ($past(opt_reg[pmoc_pkg::B_MLO_SEL])
        ? pmoc_pkg::MLO_RESTORE_1 : pmoc_pkg::MLO_RESTORE_0))
        else $error("Margin low restore value wrong.");
    a_fast_freeze: assert property (vout_only_fast_measure && $stable(vout_only_fast_measure) [*3] |-> ##2 $stable(read_iout_out))
        else $error("Current reading moved in fast mode.");
    a_read_back: assert property (opt_rd_in |=> opt_rdata_out == $past(opt_reg))
        else $error("Options read returned stale value.");

    c_override_write: cover property (bad_write_in && wlo ##1 write_accept_out);
    c_auto_mask: cover property (ara_done_in && fault_active_in != '0 ##1 fault_mask_set_out != '0);
    c_vsm_toggle: cover property ($rose(vout_only_fast_measure) ##[1:100] res_valid[pmoc_pkg::CH_VOUT]);
    c_restore: cover property (input_undervoltage_shutdown_in ##1 vout_restore_out);
endmodule

/* src/pmoc_pkg.sv */
// Function
// - Override on accepts otherwise rejected writes
// - Override writes set no flag, no alert
// - Clearing override raises no late alert
// - Override bit never saved or restored
// - Averaging codes 00=16, 10=8, 11=32
// - Averaging resets to 00, saved and restored
// - Averaging code 01 passes every sample
// - Fast mode change: first average lacks sample
// - Auto mask set faults after alert response
// - Auto mask off: host masks faults itself
// - Nonzero range code forces measurement divider
// - Range 00: divider follows loop scale
// - Restore setpoint on any shutdown when enabled
// - Margin low restore: fff7 or fff1
// - Margin high restore: 0009 or 000f
// - Fast mode stops current, temperature updates
// - Store-all command saves options to memory
package pmoc_pkg;
    // ==========================================================
    // Options register layout
    localparam int OPT_W = 16;
    localparam logic [15:0] OPT_RESET = 16'h1084;
    localparam logic [15:0] OPT_WR_MASK = 16'h7fff;
    // Fields without nonvolatile backup are left out of this mask.
    localparam logic [15:0] OPT_NV_MASK = 16'h7fe7;
    localparam int B_MHI_SEL = 14;
    localparam int B_MLO_SEL = 13;
    localparam int B_RST_VOUT = 11;
    localparam int B_RANGE_HI = 9;
    localparam int B_RANGE_LO = 8;
    localparam int B_AUTO_ARA = 7;
    localparam int B_AVG_HI = 6;
    localparam int B_AVG_LO = 5;
    localparam int B_WLO = 4;
    localparam int B_VSM = 3;
    // ==========================================================
    // Averaging codes and shift amounts
    localparam logic [1:0] AVG_16 = 2'h0;
    localparam logic [1:0] AVG_BYPASS = 2'h1;
    localparam logic [1:0] AVG_8 = 2'h2;
    localparam logic [1:0] AVG_32 = 2'h3;
    localparam logic [2:0] SH_8 = 3'h3;
    localparam logic [2:0] SH_16 = 3'h4;
    localparam logic [2:0] SH_32 = 3'h5;
    // ==========================================================
    // Divider choices and loop scale codes
    typedef enum logic [1:0] {
        PMOC_DIV_HALF,
        PMOC_DIV_QUARTER,
        PMOC_DIV_EIGHTH
    } pmoc_div_t;
    localparam logic [1:0] RANGE_AUTO = 2'h0;
    localparam logic [1:0] RANGE_EIGHTH = 2'h1;
    localparam logic [1:0] RANGE_QUARTER = 2'h2;
    localparam logic [1:0] SCALE_ONE = 2'h0;
    localparam logic [1:0] SCALE_HALF = 2'h1;
    // ==========================================================
    // Margin restore values and channel numbers
    localparam logic [15:0] MLO_RESTORE_0 = 16'hfff7;
    localparam logic [15:0] MLO_RESTORE_1 = 16'hfff1;
    localparam logic [15:0] MHI_RESTORE_0 = 16'h0009;
    localparam logic [15:0] MHI_RESTORE_1 = 16'h000f;
    localparam int NCH = 3;
    localparam logic [1:0] CH_VOUT = 2'h0;
    localparam logic [1:0] CH_IOUT = 2'h1;
    localparam logic [1:0] CH_TEMP = 2'h2;
endpackage
